// >>> adc_pat.sv
// Output FIFO and register bank with per-channel test-pattern generators
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Output FIFO
module adc_pat_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_ptr <= '0;
      end else if (push) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_ptr <= '0;
      end else if (pop) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top: APB register bank and pattern generation
module adc_pat #(
   parameter int DEPTH = adc_pat_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Converter samples
   input wire logic SAMPLE_VALID,
   input wire adc_pat_pkg::sample_t SAMPLE_IN,
   output logic SAMPLE_READY,
   // Output words
   output logic OUT_VALID,
   output adc_pat_pkg::out_word_t OUT_WORD,
   input wire logic OUT_READY
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Selector decode, second pair uses its own code map
   function automatic adc_pat_pkg::pat_kind_t decode_sel(input logic [3:0] sel,
                                                         input logic second_pair);
      adc_pat_pkg::pat_kind_t kind;
      kind = adc_pat_pkg::PAT_NORMAL;
      if (sel == adc_pat_pkg::SEL_ZEROS) begin
         kind = adc_pat_pkg::PAT_ZEROS;
      end else if (sel == adc_pat_pkg::SEL_ONES) begin
         kind = adc_pat_pkg::PAT_ONES;
      end else if (sel == adc_pat_pkg::SEL_TOGGLE) begin
         kind = adc_pat_pkg::PAT_TOGGLE;
      end else if (sel == adc_pat_pkg::SEL_RAMP) begin
         kind = adc_pat_pkg::PAT_RAMP;
      end else if (!second_pair) begin
         if (sel == adc_pat_pkg::SEL_AB_CUSTOM) begin
            kind = adc_pat_pkg::PAT_CUSTOM;
         end else if (sel == adc_pat_pkg::SEL_AB_DESKEW) begin
            kind = adc_pat_pkg::PAT_DESKEW;
         end else if (sel == adc_pat_pkg::SEL_AB_PRBS) begin
            kind = adc_pat_pkg::PAT_PRBS;
         end else if (sel == adc_pat_pkg::SEL_AB_SINE) begin
            kind = adc_pat_pkg::PAT_SINE;
         end
      end else begin
         if (sel == adc_pat_pkg::SEL_CD_CUSTOM) begin
            kind = adc_pat_pkg::PAT_CUSTOM;
         end else if (sel == adc_pat_pkg::SEL_CD_DESKEW) begin
            kind = adc_pat_pkg::PAT_DESKEW;
         end else if (sel == adc_pat_pkg::SEL_CD_PRBS) begin
            kind = adc_pat_pkg::PAT_PRBS;
         end else if (sel == adc_pat_pkg::SEL_CD_SINE) begin
            kind = adc_pat_pkg::PAT_SINE;
         end
      end
      // unlisted codes fall back to normal data
      return kind;
   endfunction

   function automatic logic [11:0] sine_word(input logic [2:0] idx);
      logic [11:0] w;
      w = adc_pat_pkg::SINE_0;
      unique case (idx)
         3'h0: w = adc_pat_pkg::SINE_0;
         3'h1: w = adc_pat_pkg::SINE_1;
         3'h2: w = adc_pat_pkg::SINE_2;
         3'h3: w = adc_pat_pkg::SINE_3;
         3'h4: w = adc_pat_pkg::SINE_4;
         3'h5: w = adc_pat_pkg::SINE_3;
         3'h6: w = adc_pat_pkg::SINE_2;
         3'h7: w = adc_pat_pkg::SINE_1;
      endcase
      return w;
   endfunction

   // Channels past the first half use the second selector register
   function automatic logic second_pair_ch(input int ch);
      return ch >= adc_pat_pkg::CH_COUNT / 2;
   endfunction

   // Advance one generator by one sample
   function automatic adc_pat_pkg::gen_state_t gen_step(input adc_pat_pkg::gen_state_t s);
      adc_pat_pkg::gen_state_t n;
      n = s;
      n.ramp = s.ramp + 12'h001;
      n.sine = s.sine + 3'h1;
      n.toggle = !s.toggle;
      n.prbs = {s.prbs[adc_pat_pkg::PRBS_W-2:0],
                s.prbs[adc_pat_pkg::PRBS_TAP_A] ^ s.prbs[adc_pat_pkg::PRBS_TAP_B]};
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers and APB decode

   adc_pat_pkg::cfg_t cfg;
   logic [5:0] idx;
   logic mapped;
   logic wr_access;
   logic soft_rst;
   logic ctrl_wr;
   logic ovr_wr;
   logic fmt_wr;
   logic sel_ab_wr;
   logic sel_cd_wr;
   logic cust_hi_wr;
   logic cust_lo_wr;
   logic [7:0] next_rdata;

   assign idx = PADDR[7:adc_pat_pkg::ADDR_SHIFT];
   assign mapped = (PADDR[adc_pat_pkg::ADDR_SHIFT-1:0] == 2'h0) &&
                   (idx == adc_pat_pkg::IDX_CTRL || idx == adc_pat_pkg::IDX_OVR ||
                    idx == adc_pat_pkg::IDX_FMT || idx == adc_pat_pkg::IDX_SEL_AB ||
                    idx == adc_pat_pkg::IDX_SEL_CD || idx == adc_pat_pkg::IDX_CUST_HI ||
                    idx == adc_pat_pkg::IDX_CUST_LO);
   assign wr_access = PSEL && PENABLE && PWRITE && mapped;
   // One write strobe per register
   assign ctrl_wr = wr_access && idx == adc_pat_pkg::IDX_CTRL;
   assign ovr_wr = wr_access && idx == adc_pat_pkg::IDX_OVR;
   assign fmt_wr = wr_access && idx == adc_pat_pkg::IDX_FMT;
   assign sel_ab_wr = wr_access && idx == adc_pat_pkg::IDX_SEL_AB;
   assign sel_cd_wr = wr_access && idx == adc_pat_pkg::IDX_SEL_CD;
   assign cust_hi_wr = wr_access && idx == adc_pat_pkg::IDX_CUST_HI;
   assign cust_lo_wr = wr_access && idx == adc_pat_pkg::IDX_CUST_LO;
   assign soft_rst = ctrl_wr && PWDATA[adc_pat_pkg::BIT_SRST];
   assign PREADY = 1'b1;

   // reserved bits are simply not stored
   always_ff @(posedge MCLK) begin
      if (!NRST || soft_rst) begin
         // defaults restored, reset bit never stored
         cfg <= adc_pat_pkg::CFG_DEFAULT;
      end else if (wr_access) begin
         if (ctrl_wr) begin
            cfg.pat_en <= PWDATA[adc_pat_pkg::BIT_PAT_EN];
         end
         if (ovr_wr) begin
            cfg.ovr_lsb <= PWDATA[adc_pat_pkg::BIT_OVR_LSB];
         end
         if (fmt_wr) begin
            cfg.align <= PWDATA[adc_pat_pkg::BIT_ALIGN];
            cfg.fmt <= PWDATA[adc_pat_pkg::BIT_FORMAT];
         end
         if (sel_ab_wr) begin
            cfg.sel[0] <= PWDATA[adc_pat_pkg::SEL_HI_LSB +: adc_pat_pkg::SEL_W];
            cfg.sel[1] <= PWDATA[0 +: adc_pat_pkg::SEL_W];
         end
         if (sel_cd_wr) begin
            cfg.sel[2] <= PWDATA[adc_pat_pkg::SEL_HI_LSB +: adc_pat_pkg::SEL_W];
            cfg.sel[3] <= PWDATA[0 +: adc_pat_pkg::SEL_W];
         end
         if (cust_hi_wr) begin
            cfg.custom[11:adc_pat_pkg::CUST_LO_W] <= PWDATA[7:0];
         end
         if (cust_lo_wr) begin
            cfg.custom[adc_pat_pkg::CUST_LO_W-1:0] <=
               PWDATA[adc_pat_pkg::CUST_LO_LSB +: adc_pat_pkg::CUST_LO_W];
         end
      end
   end

   // Read mux, reserved bits read zero
   always_comb begin
      next_rdata = 8'h00;
      if (idx == adc_pat_pkg::IDX_CTRL) begin
         next_rdata[adc_pat_pkg::BIT_PAT_EN] = cfg.pat_en;
      end else if (idx == adc_pat_pkg::IDX_OVR) begin
         next_rdata[adc_pat_pkg::BIT_OVR_LSB] = cfg.ovr_lsb;
      end else if (idx == adc_pat_pkg::IDX_FMT) begin
         next_rdata[adc_pat_pkg::BIT_ALIGN] = cfg.align;
         next_rdata[adc_pat_pkg::BIT_FORMAT] = cfg.fmt;
      end else if (idx == adc_pat_pkg::IDX_SEL_AB) begin
         next_rdata = {cfg.sel[0], cfg.sel[1]};
      end else if (idx == adc_pat_pkg::IDX_SEL_CD) begin
         next_rdata = {cfg.sel[2], cfg.sel[3]};
      end else if (idx == adc_pat_pkg::IDX_CUST_HI) begin
         next_rdata = cfg.custom[11:adc_pat_pkg::CUST_LO_W];
      end else if (idx == adc_pat_pkg::IDX_CUST_LO) begin
         next_rdata = {cfg.custom[adc_pat_pkg::CUST_LO_W-1:0], 4'h0};
      end
   end

   // Read data captured in the setup cycle, refused reads give zero
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         PRDATA <= 32'h00000000;
      end else if (PSEL && !PENABLE) begin
         PRDATA <= {24'h000000, mapped ? next_rdata : 8'h00};
      end
   end

   // Refusal flag captured in the setup cycle
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         PSLVERR <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         PSLVERR <= !mapped;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pattern generators, one per channel and one shared for alignment

   adc_pat_pkg::gen_state_t gen [adc_pat_pkg::CH_COUNT];
   adc_pat_pkg::gen_state_t shared_gen;
   adc_pat_pkg::out_word_t next_word;
   logic accept;

   assign accept = SAMPLE_VALID && SAMPLE_READY;

   // free-running channels restart on selector write
   always_ff @(posedge MCLK) begin
      if (!NRST || soft_rst) begin
         for (int i = 0; i < adc_pat_pkg::CH_COUNT; i++) begin
            gen[i] <= adc_pat_pkg::GEN_INIT;
         end
      end else begin
         for (int i = 0; i < adc_pat_pkg::CH_COUNT; i++) begin
            if (second_pair_ch(i) ? sel_cd_wr : sel_ab_wr) begin
               gen[i] <= adc_pat_pkg::GEN_INIT;
            end else if (accept) begin
               gen[i] <= gen_step(gen[i]);
            end
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!NRST || soft_rst) begin
         shared_gen <= adc_pat_pkg::GEN_INIT;
      end else if (accept) begin
         shared_gen <= gen_step(shared_gen);
      end
   end

   always_comb begin
      adc_pat_pkg::gen_state_t s;
      adc_pat_pkg::pat_kind_t kind;
      logic [11:0] w;
      s = adc_pat_pkg::GEN_INIT;
      kind = adc_pat_pkg::PAT_NORMAL;
      w = adc_pat_pkg::WORD_ZEROS;
      next_word = '0;
      for (int i = 0; i < adc_pat_pkg::CH_COUNT; i++) begin
         s = cfg.align ? shared_gen : gen[i];
         // selectors act only with pattern enable
         kind = cfg.pat_en ? decode_sel(cfg.sel[i], second_pair_ch(i)) :
                             adc_pat_pkg::PAT_NORMAL;
         w = SAMPLE_IN.ch[i];
         // offset binary flips the sign bit
         if (cfg.fmt) begin
            w[adc_pat_pkg::SAMPLE_MSB] = !w[adc_pat_pkg::SAMPLE_MSB];
         end
         if (cfg.ovr_lsb) begin
            w[0] = SAMPLE_IN.overrange_flag;
         end
         unique case (kind)
            adc_pat_pkg::PAT_NORMAL: next_word.ch[i] = w;
            adc_pat_pkg::PAT_ZEROS: next_word.ch[i] = adc_pat_pkg::WORD_ZEROS;
            adc_pat_pkg::PAT_ONES: next_word.ch[i] = adc_pat_pkg::WORD_ONES;
            adc_pat_pkg::PAT_TOGGLE: next_word.ch[i] =
               s.toggle ? adc_pat_pkg::TOGGLE_SECOND : adc_pat_pkg::TOGGLE_FIRST;
            adc_pat_pkg::PAT_RAMP: next_word.ch[i] = s.ramp;
            adc_pat_pkg::PAT_CUSTOM: next_word.ch[i] = cfg.custom;
            adc_pat_pkg::PAT_DESKEW: next_word.ch[i] = adc_pat_pkg::WORD_DESKEW;
            adc_pat_pkg::PAT_PRBS: next_word.ch[i] = s.prbs[11:0];
            adc_pat_pkg::PAT_SINE: next_word.ch[i] = sine_word(s.sine);
            default: next_word.ch[i] = w;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output buffering

   adc_pat_fifo #(
      .WIDTH($bits(adc_pat_pkg::out_word_t)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(MCLK),
      .nrst(NRST),
      .in_valid(SAMPLE_VALID),
      .in_data(next_word),
      .in_ready(SAMPLE_READY),
      .out_valid(OUT_VALID),
      .out_data(OUT_WORD),
      .out_ready(OUT_READY)
   );

endmodule

// >>> adc_pat_pkg.sv
// Constants and types for the converter output test-pattern block
// Operation
// - Pattern enable low gives normal data
// - Soft reset restores defaults, then self-clears
// - Overrange flag may replace output bit 0
// - Align bit locks all channel generators together
// - Format bit picks twos complement or offset
// - Four-bit selector per channel, two per register
// - Codes zero, one, two: normal, zeros, ones
// - Code three toggles AAA and 555 words
// - Code four ramps one code per sample
// - First pair codes for custom, deskew, PRBS, sine
// - Second pair uses shifted custom/deskew/PRBS/sine codes
// - Custom code outputs the programmed custom word
// - Sine code repeats the eight fixed samples
// - Custom word split over two registers
package adc_pat_pkg;

   localparam int CH_COUNT = 4;
   localparam int SAMPLE_W = 12;
   localparam int SEL_W = 4;
   localparam int FIFO_DEPTH = 8;

   // Register indices, byte address is index shifted by ADDR_SHIFT
   localparam logic [5:0] IDX_CTRL = 6'h06;
   localparam logic [5:0] IDX_OVR = 6'h07;
   localparam logic [5:0] IDX_FMT = 6'h09;
   localparam logic [5:0] IDX_SEL_AB = 6'h0A;
   localparam logic [5:0] IDX_SEL_CD = 6'h0B;
   localparam logic [5:0] IDX_CUST_HI = 6'h0E;
   localparam logic [5:0] IDX_CUST_LO = 6'h0F;
   localparam int ADDR_SHIFT = 2;

   // Field positions
   localparam int BIT_SRST = 0;
   localparam int BIT_PAT_EN = 1;
   localparam int BIT_OVR_LSB = 0;
   localparam int BIT_FORMAT = 0;
   localparam int BIT_ALIGN = 1;
   localparam int SEL_HI_LSB = 4;
   localparam int CUST_LO_LSB = 4;
   localparam int CUST_LO_W = 4;
   localparam int SAMPLE_MSB = 11;

   // Selector codes
   localparam logic [3:0] SEL_NORMAL = 4'h0;
   localparam logic [3:0] SEL_ZEROS = 4'h1;
   localparam logic [3:0] SEL_ONES = 4'h2;
   localparam logic [3:0] SEL_TOGGLE = 4'h3;
   localparam logic [3:0] SEL_RAMP = 4'h4;
   localparam logic [3:0] SEL_AB_CUSTOM = 4'h5;
   localparam logic [3:0] SEL_AB_DESKEW = 4'h6;
   localparam logic [3:0] SEL_AB_PRBS = 4'h8;
   localparam logic [3:0] SEL_AB_SINE = 4'h9;
   localparam logic [3:0] SEL_CD_CUSTOM = 4'h6;
   localparam logic [3:0] SEL_CD_DESKEW = 4'h8;
   localparam logic [3:0] SEL_CD_PRBS = 4'hA;
   localparam logic [3:0] SEL_CD_SINE = 4'hB;

   // Pattern words
   localparam logic [11:0] WORD_ZEROS = 12'h000;
   localparam logic [11:0] WORD_ONES = 12'hFFF;
   localparam logic [11:0] WORD_DESKEW = 12'hAAA;
   localparam logic [11:0] TOGGLE_FIRST = 12'hAAA;
   localparam logic [11:0] TOGGLE_SECOND = 12'h555;
   localparam logic [11:0] SINE_0 = 12'h000;
   localparam logic [11:0] SINE_1 = 12'h257;
   localparam logic [11:0] SINE_2 = 12'h800;
   localparam logic [11:0] SINE_3 = 12'hDA8;
   localparam logic [11:0] SINE_4 = 12'hFFF;

   // PRBS generator, x^15 + x^14 + 1
   localparam int PRBS_W = 15;
   localparam int PRBS_TAP_A = 14;
   localparam int PRBS_TAP_B = 13;
   localparam logic [14:0] PRBS_SEED = 15'h7FFF;

   typedef enum logic [3:0] {
      PAT_NORMAL, PAT_ZEROS, PAT_ONES, PAT_TOGGLE, PAT_RAMP,
      PAT_CUSTOM, PAT_DESKEW, PAT_PRBS, PAT_SINE
   } pat_kind_t;

   typedef struct packed {
      logic [11:0] ramp;
      logic toggle;
      logic [2:0] sine;
      logic [14:0] prbs;
   } gen_state_t;

   localparam gen_state_t GEN_INIT = '{ramp: 12'h000, toggle: 1'b0, sine: 3'h0,
                                       prbs: PRBS_SEED};

   typedef struct packed {
      logic overrange_flag;
      logic [3:0][11:0] ch;
   } sample_t;

   typedef struct packed {
      logic [3:0][11:0] ch;
   } out_word_t;

   typedef struct packed {
      logic pat_en;
      logic ovr_lsb;
      logic align;
      logic fmt;
      logic [3:0][3:0] sel;
      logic [11:0] custom;
   } cfg_t;

   localparam cfg_t CFG_DEFAULT = '0;

endpackage

// >>> adc_pat_chk.sv
// Port-level assertion checker for the pattern block, bound to its top
`timescale 1ns/1ps
module adc_pat_chk #(
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Streams
   input wire logic SAMPLE_VALID,
   input wire adc_pat_pkg::sample_t SAMPLE_IN,
   input wire logic SAMPLE_READY,
   input wire logic OUT_VALID,
   input wire adc_pat_pkg::out_word_t OUT_WORD,
   input wire logic OUT_READY
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);

   ////////////////////////////////////////////////////////////////////////////////
   chk_sel_readback: assert property (
      PSEL && PENABLE && PWRITE && PADDR == 8'h28 ##1 PSEL && !PENABLE && PADDR == 8'h28
      |=> PRDATA == ($past(PWDATA, 2) & 32'h0000_00FF))
      else $error("selector readback differs from written value");
   chk_srst_clears: assert property (
      PSEL && PENABLE && PWRITE && PADDR == 8'h18 && PWDATA[0] ##1
      PSEL && !PENABLE && PADDR == 8'h28 |=> PRDATA == 32'h0)
      else $error("selectors not cleared by soft reset");
   chk_srst_reads0: assert property (
      PSEL && !PENABLE && !PWRITE && PADDR == 8'h18 |=> !PRDATA[0])
      else $error("soft reset bit reads one");
   chk_reserved_zero: assert property (
      PSEL && PENABLE && !PWRITE |-> PRDATA[31:8] == 24'h0)
      else $error("reserved read bits not zero");
   chk_unmapped_err: assert property (
      PSEL && !PENABLE && PADDR == 8'h00 |=> PSLVERR && PRDATA == 32'h0)
      else $error("unmapped access not refused");
   chk_cust_low: assert property (
      PSEL && !PENABLE && !PWRITE && PADDR == 8'h3C |=> PRDATA[3:0] == 4'h0)
      else $error("custom low register reserved bits not zero");
   chk_push_shows: assert property (
      SAMPLE_VALID && SAMPLE_READY && !OUT_VALID |=> OUT_VALID)
      else $error("accepted sample not presented");
   chk_word_holds: assert property (
      OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_WORD))
      else $error("output word changed while stalled");
endmodule

bind adc_pat adc_pat_chk #(.DEPTH(DEPTH)) i_adc_pat_chk (.MCLK(MCLK), .NRST(NRST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_VALID(SAMPLE_VALID),
   .SAMPLE_IN(SAMPLE_IN), .SAMPLE_READY(SAMPLE_READY), .OUT_VALID(OUT_VALID),
   .OUT_WORD(OUT_WORD), .OUT_READY(OUT_READY));

// >>> adc_rx_model.sv
// Receiver model that drains output words slowly and records them
`timescale 1ns/1ps
module adc_rx_model (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Word stream
   input wire logic out_valid,
   input wire adc_pat_pkg::out_word_t out_word,
   output logic out_ready,
   // Control
   input wire logic stall
);
   logic [1:0] phase;
   adc_pat_pkg::out_word_t got[$];
   initial begin
      out_ready = 1'h0;
      phase = 2'h0;
   end
   // Idle one cycle in three, none taken while stalled
   always @(posedge clk) begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      out_ready <= nrst && !stall && phase != 2'h0;
      if (nrst && out_valid && out_ready) begin
         got.push_back(out_word);
      end
   end
endmodule

// >>> tb.sv
// Self-checking bench for the pattern block
`timescale 1ns/1ps
module tb;
   localparam int LIMIT = 20000;
   typedef struct {logic pen; logic [1:0] fo; logic [3:0] ab; logic [3:0] cd;
                   int kind; int n;} row_t;
   logic MCLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, stall;
   logic SAMPLE_VALID, SAMPLE_READY, OUT_VALID, OUT_READY;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   adc_pat_pkg::sample_t SAMPLE_IN;
   adc_pat_pkg::out_word_t OUT_WORD;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [11:0] sine[8] = '{12'h000, 12'h257, 12'h800, 12'hDA8, 12'hFFF, 12'hDA8, 12'h800, 12'h257};
   logic [7:0] regs[7] = '{8'h18, 8'h1C, 8'h24, 8'h28, 8'h2C, 8'h38, 8'h3C};
   // rows use listed selector codes only
   row_t rows[11] = '{'{1'h1, 2'h0, 4'h0, 4'h0, 0, 10}, '{1'h1, 2'h3, 4'h0, 4'h0, 0, 10},
      '{1'h0, 2'h0, 4'h1, 4'h1, 0, 10}, '{1'h1, 2'h0, 4'h1, 4'h1, 1, 10},
      '{1'h1, 2'h0, 4'h2, 4'h2, 2, 10}, '{1'h1, 2'h0, 4'h3, 4'h3, 3, 10},
      '{1'h1, 2'h0, 4'h4, 4'h4, 4, 4100}, '{1'h1, 2'h0, 4'h5, 4'h6, 5, 10},
      '{1'h1, 2'h0, 4'h6, 4'h8, 6, 10}, '{1'h1, 2'h0, 4'h8, 4'hA, 7, 10},
      '{1'h1, 2'h0, 4'h9, 4'hB, 8, 10}};

   adc_pat #(.DEPTH(8)) i_adc_pat (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_IN(SAMPLE_IN),
      .SAMPLE_READY(SAMPLE_READY), .OUT_VALID(OUT_VALID), .OUT_WORD(OUT_WORD),
      .OUT_READY(OUT_READY));
   adc_rx_model i_adc_rx_model (.clk(MCLK), .nrst(NRST), .out_valid(OUT_VALID),
      .out_word(OUT_WORD), .out_ready(OUT_READY), .stall(stall));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [11:0] samp(input int k, input int c);
      return 12'(12'h123 * (c + 1) + k);
   endfunction

   function automatic logic [11:0] expv(input int kind, input int k, input int c,
                                        input logic [1:0] fo);
      logic [14:0] s;
      logic [11:0] v;
      s = 15'h7FFF;
      v = samp(k, c);
      if (fo[1]) v[11] = ~v[11];
      if (fo[0]) v[0] = k[0];
      case (kind)
         1: v = 12'h000;
         2: v = 12'hFFF;
         3: v = k[0] ? 12'h555 : 12'hAAA;
         4: v = k[11:0];
         5: v = 12'hABC;
         6: v = 12'hAAA;
         7: begin
            for (int i = 0; i < k; i++) s = {s[13:0], s[14] ^ s[13]};
            v = s[11:0];
         end
         8: v = sine[k % 8];
         default: ;
      endcase
      return v;
   endfunction

   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'h1;
      PENABLE <= 1'h0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'h1;
      do @(posedge MCLK); while (PREADY !== 1'h1);
      rd = PRDATA;
   endtask

   task automatic idle();
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
      @(posedge MCLK);
   endtask

   task automatic feed(input int n, input int base);
      i_adc_rx_model.got.delete();
      for (int k = base; k < base + n; k++) begin
         SAMPLE_VALID <= 1'h1;
         for (int c = 0; c < 4; c++) SAMPLE_IN.ch[c] <= samp(k, c);
         SAMPLE_IN.overrange_flag <= k[0];
         do @(posedge MCLK); while (SAMPLE_READY !== 1'h1);
      end
      SAMPLE_VALID <= 1'h0;
      @(posedge MCLK);
   endtask

   task automatic drain(input int kind, input int n, input logic [1:0] fo, input int base);
      while (i_adc_rx_model.got.size() < n) @(posedge MCLK);
      for (int k = 0; k < n; k++) begin
         for (int c = 0; c < 4; c++) begin
            chk(i_adc_rx_model.got[k].ch[c], expv(kind, k + base, c, fo));
         end
      end
   endtask

   task automatic final_report();
      $display("Checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always #12.5 MCLK = ~MCLK;

   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         num_errors++;
         final_report();
      end
   end

   initial begin
      MCLK = 1'h0;
      NRST = 1'h0;
      {PSEL, PENABLE, PWRITE, stall, SAMPLE_VALID} = 5'h00;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      SAMPLE_IN = '0;
      repeat (16) @(posedge MCLK);
      NRST <= 1'h1;
      foreach (rows[i]) begin
         apb(1'h1, 8'h18, {30'h0, rows[i].pen, 1'h0});
         apb(1'h1, 8'h1C, {31'h0, rows[i].fo[0]});
         apb(1'h1, 8'h24, {31'h0, rows[i].fo[1]});
         apb(1'h1, 8'h28, {24'h0, rows[i].ab, rows[i].ab});
         apb(1'h1, 8'h2C, {24'h0, rows[i].cd, rows[i].cd});
         apb(1'h1, 8'h38, 32'hAB);
         apb(1'h1, 8'h3C, 32'hC0);
         idle();
         feed(rows[i].n, 0);
         drain(rows[i].kind, rows[i].n, rows[i].fo, 0);
      end
      // Readback, refusal and soft reset
      apb(1'h0, 8'h38, 32'h0);
      chk(rd, 32'hAB);
      apb(1'h0, 8'h00, 32'h0);
      chk({PSLVERR, rd}, {1'h1, 32'h0});
      apb(1'h1, 8'h28, 32'h59);
      apb(1'h0, 8'h28, 32'h0);
      chk(rd, 32'h59);
      apb(1'h1, 8'h18, 32'h3);
      apb(1'h0, 8'h28, 32'h0);
      chk(rd, 32'h0);
      foreach (rows[i]) begin
         apb(1'h0, regs[i % 7], 32'h0);
         chk(rd, 32'h0);
      end
      // Fill until refused, then drain
      idle();
      stall <= 1'h1;
      feed(8, 0);
      chk({SAMPLE_READY, OUT_VALID}, 2'h1);
      stall <= 1'h0;
      drain(0, 8, 2'h0, 0);
      // Aligned generators ignore selector rewrites
      apb(1'h1, 8'h18, 32'h1);
      apb(1'h1, 8'h18, 32'h2);
      apb(1'h1, 8'h24, 32'h2);
      apb(1'h1, 8'h28, 32'h44);
      apb(1'h1, 8'h2C, 32'h44);
      idle();
      feed(5, 0);
      drain(4, 5, 2'h0, 0);
      apb(1'h1, 8'h28, 32'h44);
      idle();
      feed(3, 5);
      drain(4, 3, 2'h0, 5);
      // Unaligned access refused and reads zero
      apb(1'h0, 8'h1A, 32'h0);
      chk({PSLVERR, rd}, {1'h1, 32'h0});
      // Mid-run reset
      idle();
      NRST <= 1'h0;
      repeat (2) @(posedge MCLK);
      chk({OUT_VALID, SAMPLE_READY, PSLVERR, PREADY}, 4'h5);
      NRST <= 1'h1;
      apb(1'h0, 8'h18, 32'h0);
      chk(rd, 32'h0);
      final_report();
   end
endmodule
